// File: hdl/txe_pkg.sv
// Package of constants for the table-write, test-skip and xor execution block.
package txe_pkg;
   localparam int PTR_W       = 21;
   localparam int HOLD_CNT    = 8;
   localparam int HOLD_IDX_W  = 3;
   localparam int DATA_W      = 8;
   localparam int FADDR_W     = 12;
   localparam int CLK_HZ      = 10000000;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   // Opcode patterns.
   localparam logic [15:0] TWR_MASK    = 16'hfffc;
   localparam logic [15:0] TWR_CODE    = 16'h000c;
   localparam logic [15:0] TSTSZ_MASK  = 16'hfe00;
   localparam logic [15:0] TSTSZ_CODE  = 16'h6600;
   localparam logic [15:0] XORL_MASK   = 16'hff00;
   localparam logic [15:0] XORL_CODE   = 16'h0a00;
   localparam logic [15:0] XORF_MASK   = 16'hfc00;
   localparam logic [15:0] XORF_CODE   = 16'h1800;
   // Field positions.
   localparam int BIT_ACCESS  = 8;
   localparam int BIT_DEST    = 9;
   localparam int BIT_BYTESEL = 0;
   localparam int STAT_N      = 4;
   localparam int STAT_Z      = 2;
   // Pointer treatment codes in the two low opcode bits.
   localparam logic [1:0] MODE_KEEP     = 2'h0;
   localparam logic [1:0] MODE_POST_INC = 2'h1;
   localparam logic [1:0] MODE_POST_DEC = 2'h2;
   localparam logic [1:0] MODE_PRE_INC  = 2'h3;
   // Quarter phases, one-hot.
   typedef enum logic [3:0] {
      Q1 = 4'h1,
      Q2 = 4'h2,
      Q3 = 4'h4,
      Q4 = 4'h8
   } txe_q_e;
   // Instruction cycle sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_EXEC  = 4'h1,
      ST_TBLW2 = 4'h2,
      ST_SKIP1 = 4'h4,
      ST_SKIP2 = 4'h8
   } txe_st_e;
endpackage

// File: hdl/txe_hold_mem.sv
// Eight-byte holding register store with registered read data.
module txe_hold_mem (
   // Clock and control.
   input  wire logic                              sys_clk,
   input  wire logic                              clk_en,
   // Write port.
   input  wire logic                              wr_en,
   input  wire logic [txe_pkg::HOLD_IDX_W-1:0]    wr_idx,
   input  wire logic [txe_pkg::DATA_W-1:0]        wr_data,
   // Read port.
   input  wire logic [txe_pkg::HOLD_IDX_W-1:0]    rd_idx,
   output logic      [txe_pkg::DATA_W-1:0]        rd_data
);
   logic [txe_pkg::DATA_W-1:0] mem [txe_pkg::HOLD_CNT];

   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem[wr_idx] <= wr_data;
         end
         rd_data <= mem[rd_idx];
      end
   end
endmodule

// File: hdl/txe_exec.sv
// Execution logic for table write, test-and-skip and the two xor instructions.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
module txe_exec (
   // Clock, enable and reset.
   input  wire logic                              sys_clk,
   input  wire logic                              clk_en,
   input  wire logic                              reset,
   // Instruction issue.
   input  wire logic                              instr_valid,
   input  wire logic [15:0]                       instr_word,
   input  wire logic                              next_is_two_word,
   // Core state supplied by the datapath.
   input  wire logic [txe_pkg::DATA_W-1:0]        table_latch,
   input  wire logic [3:0]                        bank_select_register,
   input  wire logic [txe_pkg::DATA_W-1:0]        file_rd_data,
   input  wire logic [txe_pkg::DATA_W-1:0]        status_in,
   // Holding register readback.
   input  wire logic [txe_pkg::HOLD_IDX_W-1:0]    hold_rd_idx,
   output logic      [txe_pkg::DATA_W-1:0]        hold_rd_data,
   // File register access.
   output logic      [txe_pkg::FADDR_W-1:0]       file_addr,
   output logic                                   file_wr_en,
   output logic      [txe_pkg::DATA_W-1:0]        file_wr_data,
   // Core results.
   output logic      [txe_pkg::DATA_W-1:0]        working_reg,
   output logic      [txe_pkg::DATA_W-1:0]        status_out,
   output logic                                   status_wr_en,
   output logic      [txe_pkg::PTR_W-1:0]         program_byte_pointer,
   output logic                                   byte_is_high,
   output logic                                   discard_prefetch,
   output logic                                   busy,
   output logic      [3:0]                        q_phase
);
   txe_pkg::txe_q_e  q_reg;
   txe_pkg::txe_q_e  q_next;
   txe_pkg::txe_st_e st_reg;
   txe_pkg::txe_st_e st_next;

   logic [15:0]                   ir_reg;
   logic [txe_pkg::PTR_W-1:0]     ptr_reg;
   logic [txe_pkg::PTR_W-1:0]     ptr_next;
   logic [txe_pkg::HOLD_IDX_W-1:0] hold_idx_reg;
   logic [txe_pkg::DATA_W-1:0]    w_reg;
   logic [txe_pkg::DATA_W-1:0]    w_next;
   logic [txe_pkg::DATA_W-1:0]    stat_reg;
   logic                          stat_wr_reg;
   logic [txe_pkg::DATA_W-1:0]    fwd_reg;
   logic                          fwe_reg;
   logic                          disc_reg;
   logic                          skip2_reg;

   // Match an opcode against its mask and pattern.
   function automatic logic op_match(input logic [15:0] word, input logic [15:0] mask,
                                     input logic [15:0] code);
      op_match = (word & mask) == code;
   endfunction

   // Zero and negative flags folded into a status byte.
   function automatic logic [txe_pkg::DATA_W-1:0] nz_flags(
         input logic [txe_pkg::DATA_W-1:0] st, input logic [txe_pkg::DATA_W-1:0] res);
      logic [txe_pkg::DATA_W-1:0] s;
      s = st;
      s[txe_pkg::STAT_N] = res[txe_pkg::DATA_W-1];
      s[txe_pkg::STAT_Z] = (res == '0);
      nz_flags = s;
   endfunction

   wire is_q1   = (q_reg == txe_pkg::Q1);
   wire is_q4   = (q_reg == txe_pkg::Q4);
   wire issue   = instr_valid && (st_reg == txe_pkg::ST_EXEC) && is_q1;
   wire [15:0] iw = issue ? instr_word : ir_reg;

   wire dec_tblw = op_match(iw, txe_pkg::TWR_MASK, txe_pkg::TWR_CODE);
   wire dec_tst  = op_match(iw, txe_pkg::TSTSZ_MASK, txe_pkg::TSTSZ_CODE);
   wire dec_xorl = op_match(iw, txe_pkg::XORL_MASK, txe_pkg::XORL_CODE);
   wire dec_xorf = op_match(iw, txe_pkg::XORF_MASK, txe_pkg::XORF_CODE);
   wire [1:0] ptr_mode = ir_reg[1:0];

   // Access bank when the access bit is clear: low half in bank 0, high half in bank 15.
   wire [3:0] bank_sel = ir_reg[txe_pkg::BIT_ACCESS] ? bank_select_register
                         : {4{ir_reg[7]}};
   assign file_addr = {bank_sel, ir_reg[7:0]};

   wire in_exec    = (st_reg == txe_pkg::ST_EXEC) && !is_q1;
   wire exec_tst   = in_exec && op_match(ir_reg, txe_pkg::TSTSZ_MASK, txe_pkg::TSTSZ_CODE);
   wire exec_xorl  = in_exec && op_match(ir_reg, txe_pkg::XORL_MASK, txe_pkg::XORL_CODE);
   wire exec_xorf  = in_exec && op_match(ir_reg, txe_pkg::XORF_MASK, txe_pkg::XORF_CODE);
   wire [txe_pkg::DATA_W-1:0] xorl_res = w_reg ^ ir_reg[7:0];
   wire [txe_pkg::DATA_W-1:0] xorf_res = w_reg ^ file_rd_data;
   wire xorf_to_file = ir_reg[txe_pkg::BIT_DEST];
   wire tst_zero = (file_rd_data == '0);

   // Pre-increment updates the pointer in the first cycle so the write sees it.
   wire tbl_first = in_exec && is_q4 && op_match(ir_reg, txe_pkg::TWR_MASK,
                                                 txe_pkg::TWR_CODE);
   wire tbl_last  = (st_reg == txe_pkg::ST_TBLW2) && is_q4;
   wire [txe_pkg::PTR_W-1:0] ptr_inc = ptr_reg + txe_pkg::PTR_W'(1);
   wire [txe_pkg::PTR_W-1:0] ptr_dec = ptr_reg - txe_pkg::PTR_W'(1);

   always_comb begin
      ptr_next = ptr_reg;
      if (tbl_first && ptr_mode == txe_pkg::MODE_PRE_INC) begin
         ptr_next = ptr_inc;
      end else if (tbl_last && ptr_mode == txe_pkg::MODE_POST_INC) begin
         ptr_next = ptr_inc;
      end else if (tbl_last && ptr_mode == txe_pkg::MODE_POST_DEC) begin
         ptr_next = ptr_dec;
      end
   end

   always_comb begin
      q_next = txe_pkg::Q1;
      unique case (q_reg)
         txe_pkg::Q1: q_next = txe_pkg::Q2;
         txe_pkg::Q2: q_next = txe_pkg::Q3;
         txe_pkg::Q3: q_next = txe_pkg::Q4;
         txe_pkg::Q4: q_next = txe_pkg::Q1;
         default:     q_next = txe_pkg::Q1;
      endcase
   end

   always_comb begin
      st_next = st_reg;
      if (is_q4) begin
         unique case (st_reg)
            txe_pkg::ST_EXEC: begin
               if (tbl_first) begin
                  st_next = txe_pkg::ST_TBLW2;
               end else if (exec_tst && tst_zero) begin
                  st_next = txe_pkg::ST_SKIP1;
               end
            end
            txe_pkg::ST_TBLW2: st_next = txe_pkg::ST_EXEC;
            txe_pkg::ST_SKIP1: st_next = skip2_reg ? txe_pkg::ST_SKIP2
                                                   : txe_pkg::ST_EXEC;
            txe_pkg::ST_SKIP2: st_next = txe_pkg::ST_EXEC;
            default:           st_next = txe_pkg::ST_EXEC;
         endcase
      end
   end

   always_comb begin
      w_next = w_reg;
      if (exec_xorl && is_q4) begin
         w_next = xorl_res;
      end else if (exec_xorf && is_q4 && !xorf_to_file) begin
         w_next = xorf_res;
      end
   end

   // Issue and quarter-phase sequencing.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q_reg  <= txe_pkg::Q1;
         st_reg <= txe_pkg::ST_EXEC;
         ir_reg <= '0;
      end else if (clk_en) begin
         q_reg  <= q_next;
         st_reg <= st_next;
         if (issue) begin
            ir_reg <= dec_tblw | dec_tst | dec_xorl | dec_xorf ? iw : '0;
         end else if (is_q4 && !tbl_first) begin
            // A table write keeps its opcode into the second cycle for the post update.
            ir_reg <= '0;
         end
      end
   end

   // Architectural state.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ptr_reg      <= '0;
         w_reg        <= '0;
         hold_idx_reg <= '0;
         skip2_reg    <= 1'b0;
      end else if (clk_en) begin
         ptr_reg <= ptr_next;
         w_reg   <= w_next;
         if (tbl_first) begin
            hold_idx_reg <= (ptr_mode == txe_pkg::MODE_PRE_INC)
                            ? ptr_inc[txe_pkg::HOLD_IDX_W-1:0]
                            : ptr_reg[txe_pkg::HOLD_IDX_W-1:0];
         end
         if (exec_tst && is_q4) begin
            skip2_reg <= next_is_two_word;
         end
      end
   end

   // Registered side outputs; skip cycles leave all of them idle except discard_prefetch, high in the first quarter of the first skip cycle.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stat_reg    <= '0;
         stat_wr_reg <= 1'b0;
         fwd_reg     <= '0;
         fwe_reg     <= 1'b0;
         disc_reg    <= 1'b0;
      end else if (clk_en) begin
         stat_wr_reg <= 1'b0;
         fwe_reg     <= 1'b0;
         disc_reg    <= 1'b0;
         if (is_q4 && exec_xorl) begin
            stat_reg    <= nz_flags(status_in, xorl_res);
            stat_wr_reg <= 1'b1;
         end else if (is_q4 && exec_xorf) begin
            stat_reg    <= nz_flags(status_in, xorf_res);
            stat_wr_reg <= 1'b1;
            fwd_reg     <= xorf_res;
            fwe_reg     <= xorf_to_file;
         end
         if (is_q4 && exec_tst && tst_zero) begin
            disc_reg <= 1'b1;
         end
      end
   end

   txe_hold_mem u_hold (
      .sys_clk (sys_clk),
      .clk_en  (clk_en),
      .wr_en   (tbl_last && !reset),
      .wr_idx  (hold_idx_reg),
      .wr_data (table_latch),
      .rd_idx  (hold_rd_idx),
      .rd_data (hold_rd_data)
   );

   assign working_reg          = w_reg;
   assign status_out           = stat_reg;
   assign status_wr_en         = stat_wr_reg;
   assign file_wr_data         = fwd_reg;
   assign file_wr_en           = fwe_reg;
   assign program_byte_pointer = ptr_reg;
   assign byte_is_high         = ptr_reg[txe_pkg::BIT_BYTESEL];
   assign discard_prefetch     = disc_reg;
   assign busy                 = (st_reg != txe_pkg::ST_EXEC) || !is_q1;
   assign q_phase              = q_reg;
endmodule

// File: bench/txe_exec_monitor.sv
// Port-level concurrent checks for the table-write, test-skip and xor execution block.
module txe_exec_monitor (
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        clk_en,
   input wire logic        reset,
   // Instruction side.
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic        next_is_two_word,
   input wire logic [3:0]  bank_select_register,
   input wire logic [7:0]  file_rd_data,
   input wire logic [7:0]  status_in,
   // Results.
   input wire logic [11:0] file_addr,
   input wire logic        file_wr_en,
   input wire logic [7:0]  working_reg,
   input wire logic [7:0]  status_out,
   input wire logic        status_wr_en,
   input wire logic [20:0] program_byte_pointer,
   input wire logic        byte_is_high,
   input wire logic        discard_prefetch,
   input wire logic        busy,
   input wire logic [3:0]  q_phase
);
   wire logic        take   = clk_en && instr_valid && q_phase == 4'h1 && !busy;
   wire logic        is_xl  = instr_word[15:8] == 8'h0a;
   wire logic        is_xf  = instr_word[15:10] == 6'h06;
   wire logic        is_ts  = instr_word[15:9] == 7'h33;
   wire logic        is_tw  = instr_word[15:2] == 14'h0003;
   wire logic [7:0]  xl_res = working_reg ^ instr_word[7:0];
   wire logic [11:0] acc_ad = {(instr_word[7] ? 4'hf : 4'h0), instr_word[7:0]};
   wire logic [11:0] bsr_ad = {bank_select_register, instr_word[7:0]};
   wire logic [20:0] ptr_up = program_byte_pointer + 21'h1;
   wire logic [20:0] ptr_dn = program_byte_pointer - 21'h1;
   wire logic [1:0]  md     = instr_word[1:0];
   wire logic [20:0] ptr_nx = md == 2'h0 ? program_byte_pointer : (md == 2'h2 ? ptr_dn : ptr_up);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_skip_short;
      take && is_ts && !next_is_two_word ##1 file_rd_data == 8'h00;
   endsequence
   sequence s_skip_long;
      take && is_ts && next_is_two_word ##1 file_rd_data == 8'h00;
   endsequence
   a_xor_lit_result: assert property (take && is_xl
      |-> ##4 working_reg == $past(xl_res, 4)) else $error("xor literal result wrong");
   a_xor_flag_mask: assert property (take && (is_xl || is_xf) |-> ##4 status_wr_en
      && (status_out & 8'heb) == ($past(status_in, 4) & 8'heb)) else $error("xor flag mask wrong");
   a_xor_nz_value: assert property (take && is_xl |-> ##4 status_out[4] == working_reg[7]
      && status_out[2] == (working_reg == 8'h00)) else $error("xor flag value wrong");
   a_xor_file_dest: assert property (take && is_xf && instr_word[9] |-> ##4 file_wr_en
      && working_reg == $past(working_reg, 4)) else $error("xor file destination wrong");
   a_xor_work_dest: assert property (take && is_xf && !instr_word[9] |-> ##4 !file_wr_en
      && working_reg == ($past(working_reg, 4) ^ $past(file_rd_data, 3)))
      else $error("xor w wrong");
   a_access_bank: assert property ((take && (is_xf || is_ts) && !instr_word[8])
      |=> file_addr == $past(acc_ad)) else $error("access bank address wrong");
   a_bank_select: assert property ((take && (is_xf || is_ts) && instr_word[8])
      |=> file_addr == $past(bsr_ad)) else $error("banked address wrong");
   a_skip_short: assert property (s_skip_short
      |-> ##3 (discard_prefetch && busy) ##1 busy[*3] ##1 !busy)
      else $error("single skip timing wrong");
   a_skip_long: assert property (s_skip_long |-> ##3 busy[*8] ##1 !busy)
      else $error("double skip timing wrong");
   a_no_skip: assert property (take && is_ts ##1 file_rd_data != 8'h00
      |-> ##3 !discard_prefetch && !busy && !status_wr_en) else $error("non-skip wrong");
   a_tw_pointer: assert property (take && is_tw
      |-> ##1 (!status_wr_en)[*8] ##0 program_byte_pointer == $past(ptr_nx, 8))
      else $error("table pointer update wrong");
   a_byte_select: assert property (byte_is_high == program_byte_pointer[0])
      else $error("byte select wrong");
endmodule

// File: bench/txe_exec_tb_top.sv
// Self-checking testbench for the table-write, test-skip and xor execution block.
module txe_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic             sys_clk, clk_en, reset, instr_valid, next_is_two_word;
   logic [15:0]      instr_word;
   logic [7:0]       table_latch, file_rd_data, status_in;
   logic [3:0]       bank_select_register;
   logic [2:0]       hold_rd_idx;
   wire logic [7:0]  hold_rd_data, file_wr_data, working_reg, status_out;
   wire logic [11:0] file_addr;
   wire logic [20:0] program_byte_pointer;
   wire logic        file_wr_en, status_wr_en, byte_is_high, discard_prefetch, busy;
   wire logic [3:0]  q_phase;
   int               err_count, compares, cyc, k;
   logic             disc, stw, fwe;
   localparam logic [1:0]  MD [7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2, 2'h0};
   localparam logic [20:0] PX [7] = '{21'h0, 21'h1, 21'h2, 21'h1, 21'h0, 21'h1fffff, 21'h1fffff};
   txe_exec txe_exec_i (.sys_clk(sys_clk), .clk_en(clk_en), .reset(reset),
      .instr_valid(instr_valid), .instr_word(instr_word), .next_is_two_word(next_is_two_word),
      .table_latch(table_latch), .bank_select_register(bank_select_register),
      .file_rd_data(file_rd_data), .status_in(status_in), .hold_rd_idx(hold_rd_idx),
      .hold_rd_data(hold_rd_data), .file_addr(file_addr), .file_wr_en(file_wr_en),
      .file_wr_data(file_wr_data), .working_reg(working_reg), .status_out(status_out),
      .status_wr_en(status_wr_en), .program_byte_pointer(program_byte_pointer),
      .byte_is_high(byte_is_high), .discard_prefetch(discard_prefetch), .busy(busy),
      .q_phase(q_phase));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("mismatches %0d, comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Waits up to 20 cycles for a free Q1, gathering the strobes seen on the way.
   task wait_idle;
      cyc = 0;
      do begin
         @(negedge sys_clk);
         cyc++;
         disc |= discard_prefetch;
         stw |= status_wr_en;
         fwe |= file_wr_en;
      end while (!(busy === 1'b0 && q_phase === 4'h1) && cyc < 20);
      if (cyc >= 20) begin
         err_count++;
         $display("unexpected at %0t: instruction never completed", $time);
         test_done();
      end
   endtask
   // Offers one instruction, holds it through busy time, and gathers the strobes seen.
   task run(input logic [15:0] code, input logic [7:0] fd, input logic [7:0] st,
            input logic [4:0] ext);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= code;
      file_rd_data <= fd;
      table_latch <= fd;
      status_in <= st;
      bank_select_register <= ext[3:0];
      next_is_two_word <= ext[4];
      wait_idle();
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      disc = 1'b0;
      stw = 1'b0;
      fwe = 1'b0;
      wait_idle();
   endtask
   // Freezes the block with the clock enable low and checks that nothing moves.
   task t_freeze;
      run(16'hfff0, 8'h00, 8'h00, 5'h00);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({q_phase, busy, program_byte_pointer}, {4'h2, 1'b1, 21'h1fffff});
      @(posedge sys_clk);
      clk_en <= 1'b1;
   endtask
   task t_xor_lit;
      run(16'h0ab5, 8'h00, 8'h00, 5'h00);
      chk(working_reg, 8'hb5);
      chk(status_out, 8'h10);
      chk({stw, cyc[3:0]}, {1'b1, 4'h4});
      run(16'h0aaf, 8'h00, 8'hff, 5'h00);
      chk({working_reg, status_out}, 16'h1aeb);
      run(16'h0a1a, 8'h00, 8'h00, 5'h00);
      chk({working_reg, status_out}, 16'h0004);
      run(16'hfff0, 8'h00, 8'h00, 5'h00);
      chk({stw, working_reg}, 9'h000);
   endtask
   task t_xor_file;
      run(16'h0ab5, 8'h00, 8'h00, 5'h00);
      run(16'h1a85, 8'haf, 8'hff, 5'h03);
      chk({fwe, file_wr_data, working_reg, status_out}, 25'h11ab5eb);
      run(16'h1912, 8'h0f, 8'h00, 5'h03);
      chk({fwe, working_reg, status_out}, 17'h0ba10);
   endtask
   task t_skip;
      run(16'h6620, 8'h00, 8'hff, 5'h05);
      chk({disc, stw, cyc[3:0]}, 6'h28);
      run(16'h6745, 8'h00, 8'hff, 5'h12);
      chk({disc, stw, cyc[3:0]}, 6'h2c);
      run(16'h6620, 8'h01, 8'h00, 5'h10);
      chk({disc, stw, cyc[3:0]}, 6'h04);
   endtask
   task t_table;
      for (k = 0; k < 7; k++) begin
         run({14'h0003, MD[k]}, 8'(8'h11 * (k + 1)), 8'h00, 5'h00);
         chk({program_byte_pointer, byte_is_high}, {PX[k], PX[k][0]});
         chk({stw, cyc[3:0]}, 5'h08);
      end
      for (k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         hold_rd_idx <= (k == 3) ? 3'h7 : 3'(k);
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk(hold_rd_data, (k == 3) ? 8'h77 : 8'(8'h66 - 8'h11 * k));
      end
   endtask
   initial begin
      {clk_en, reset, instr_valid, next_is_two_word} = 4'hc;
      {instr_word, table_latch, file_rd_data, status_in} = '0;
      {bank_select_register, hold_rd_idx, err_count, compares} = '0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      chk({q_phase, busy, working_reg, program_byte_pointer}, 34'h040000000);
      t_xor_lit();
      t_xor_file();
      t_skip();
      t_table();
      t_freeze();
      test_done();
   end
endmodule
bind txe_exec txe_exec_monitor txe_exec_monitor_i (.sys_clk(sys_clk), .clk_en(clk_en),
   .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
   .next_is_two_word(next_is_two_word), .bank_select_register(bank_select_register),
   .file_rd_data(file_rd_data), .status_in(status_in), .file_addr(file_addr),
   .file_wr_en(file_wr_en), .working_reg(working_reg), .status_out(status_out),
   .status_wr_en(status_wr_en), .program_byte_pointer(program_byte_pointer),
   .byte_is_high(byte_is_high), .discard_prefetch(discard_prefetch), .busy(busy),
   .q_phase(q_phase));
